// ===== rtl/error_flags_pkg.sv
package error_flags_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] FLAGS_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] LIMITS_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;

  // ==========================================================================
  // Error flag positions
  localparam int FRAME_LOST_CHAN_B_BIT = 15;
  localparam int FRAME_LOST_CHAN_A_BIT = 14;
  localparam int CTRL_COMMAND_IGNORED_BIT = 13;
  localparam int RX_FIFO_OVERRUN_CHAN_B_BIT = 12;
  localparam int RX_FIFO_OVERRUN_CHAN_A_BIT = 11;
  localparam int BUFFER_SEARCH_OVERRUN_BIT = 10;
  localparam int UNUSED_BUFFER_WRITE_BIT = 9;
  localparam int BUFFER_LOCK_REFUSED_BIT = 8;
  localparam int DOUBLE_TX_LOCK_REFUSED_BIT = 7;
  localparam int SYSTEM_BUS_LATE_BIT = 6;
  localparam int FRAME_IDENT_MISMATCH_BIT = 5;
  localparam int DYNAMIC_LENGTH_ERROR_BIT = 4;
  localparam int STATIC_LENGTH_ERROR_BIT = 3;
  localparam int NETMGMT_LENGTH_ERROR_BIT = 2;
  localparam int NETMGMT_NULL_FRAME_ERROR_BIT = 1;
  localparam int ILLEGAL_MEMORY_ACCESS_BIT = 0;

  // ==========================================================================
  // Field positions
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int MAX_DYN_LSB = 0;
  localparam int STATIC_LEN_LSB = 8;
  localparam int NM_LEN_LSB = 16;
  localparam int LAST_USED_LSB = 24;
  localparam int STATUS_IRQ_BIT = 0;
  localparam int STATUS_SLOT_STOP_BIT = 1;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic IRQ_ENABLE_RESET = 1'b0;
  localparam logic [6:0] MAX_DYN_RESET = 7'h7f;
  localparam logic [6:0] STATIC_LEN_RESET = 7'h00;
  localparam logic [3:0] NM_LEN_RESET = 4'h0;
  localparam logic [6:0] LAST_USED_RESET = 7'h7f;

  // ==========================================================================
  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    PORT_IDLE = 2'b00,
    PORT_READ_WAIT = 2'b01
  } port_state_t;

endpackage

// ===== rtl/ahb_reg_port.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic wrEn,
  output logic [7:0] wrAddr,
  output logic [31:0] wrData,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData
);
  typedef struct packed {
    error_flags_pkg::port_state_t state;
    logic dataWrite;
    logic [7:0] addr;
    logic readyOut;
    logic respOut;
    logic [31:0] rdOut;
  } port_t;

  port_t portReg;
  port_t portNext;
  logic accept;

  // ==========================================================================
  // Reads take one wait state so a write just ahead is always visible
  assign accept = hsel && htrans[1] && hready && (hsize == error_flags_pkg::HSIZE_WORD);
  assign wrEn = portReg.dataWrite && hready;
  assign wrAddr = portReg.addr;
  assign wrData = hwdata;
  assign rdAddr = portReg.addr;

  always_comb begin
    portNext = portReg;
    portNext.dataWrite = 1'b0;
    portNext.respOut = error_flags_pkg::HRESP_OKAY;
    case (portReg.state)
      error_flags_pkg::PORT_IDLE: begin
        if (accept) begin
          portNext.addr = haddr[7:0];
          if (hwrite) begin
            portNext.dataWrite = 1'b1;
          end else begin
            portNext.state = error_flags_pkg::PORT_READ_WAIT;
            portNext.readyOut = 1'b0;
          end
        end
      end
      error_flags_pkg::PORT_READ_WAIT: begin
        portNext.rdOut = rdData;
        portNext.readyOut = 1'b1;
        portNext.state = error_flags_pkg::PORT_IDLE;
      end
      default: begin
        portNext.state = error_flags_pkg::PORT_IDLE;
        portNext.readyOut = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      portReg <= '{state: error_flags_pkg::PORT_IDLE, dataWrite: 1'b0, addr: 8'h00,
                   readyOut: 1'b1, respOut: error_flags_pkg::HRESP_OKAY, rdOut: 32'h0};
    end else begin
      portReg <= portNext;
    end
  end

  assign hrdata = portReg.rdOut;
  assign hreadyout = portReg.readyOut;
  assign hresp = portReg.respOut;

  a_read_wait: assert property (@(posedge clk) disable iff (!rst_b)
    (portReg.state == error_flags_pkg::PORT_IDLE && accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
endmodule
`default_nettype wire

// ===== rtl/error_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module error_flag_bank (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] setEvents,
  input wire logic [15:0] clearMask,
  output logic [15:0] flags
);
  typedef struct packed {
    logic [15:0] flags;
  } bank_t;

  bank_t bankReg;
  bank_t bankNext;
  logic [15:0] flagNext;

  // ==========================================================================
  // Per-bit write-one-to-clear, a set in the same cycle wins
  for (genvar i = 0; i < 16; i++) begin : g_flag
    assign flagNext[i] = setEvents[i] | (bankReg.flags[i] & ~clearMask[i]); // [R01] [R02] [R03]
  end

  always_comb begin
    bankNext = bankReg;
    bankNext.flags = flagNext;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bankReg.flags <= error_flags_pkg::FLAGS_RESET; // [R21]
    end else begin
      bankReg <= bankNext;
    end
  end

  assign flags = bankReg.flags;

  a_clear_by_one: assert property (@(posedge clk) disable iff (!rst_b) // [R01]
    1'b1 |=> ((flags & $past(clearMask) & ~$past(setEvents)) == 16'h0000))
    else $error("flag written with one was not cleared");
  a_zero_keeps: assert property (@(posedge clk) disable iff (!rst_b) // [R02]
    1'b1 |=> ((~flags & $past(flags) & ~$past(clearMask)) == 16'h0000))
    else $error("flag dropped without a one written");
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_b) // [R03]
    1'b1 |=> ((flags & $past(setEvents)) == $past(setEvents)))
    else $error("hardware set lost against clear");
  a_reset_clear: assert property (@(posedge clk) // [R21]
    !rst_b |=> flags == 16'h0000)
    else $error("flags not zero after reset");
endmodule
`default_nettype wire

// ===== rtl/host_interface_error_flags.sv
// What this block does
// [R01] Writing one to a flag bit clears that flag.
// [R02] Writing zero to a flag bit leaves it unchanged.
// [R03] Hardware set and software clear together leave the flag set.
// [R04] Interrupt from all flags is gated by one host interface enable.
// [R05] Bits 15/14 set when a frame hits a software-locked buffer; frame dropped.
// [R06] Bit 13 set and command dropped when written while command pending.
// [R07] Bits 12/11 set when an accepted frame meets a full receive FIFO.
// [R08] Bit 10 set when a buffer search must start while one still runs.
// [R09] Buffer control write above last used index ignored, bit 9 set.
// [R10] Lock on an internally held buffer refused, bit 8 set.
// [R11] Software repeats a refused lock request if it still needs the buffer.
// [R12] Lock of a double buffer's transmit side refused, bit 7 set.
// [R13] Bit 6 set when a system bus access completes late.
// [R14] Late write loses data; late read stops transmit until next slot.
// [R15] Bit 5 set when header frame identifier differs from control identifier.
// [R16] Bit 4 set when dynamic transmit payload length exceeds the maximum.
// [R17] Bit 3 set when static transmit payload length differs from configured.
// [R18] Bit 2 set when static receive payload is shorter than vector length.
// [R19] Bit 1 set, vector not updated, for static frame with preamble and null.
// [R20] Bit 0 set when the memory subsystem flags an illegal access.
// [R21] All sixteen flags are zero after reset.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module host_interface_error_flags (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] frameDone,
  input wire logic [1:0] bufferLocked,
  input wire logic [1:0] fifoAppendReq,
  input wire logic [1:0] fifoFull,
  input wire logic commandWrite,
  input wire logic commandPending,
  input wire logic searchStart,
  input wire logic searchRunning,
  input wire logic bufCtrlWrite,
  input wire logic [6:0] bufCtrlIndex,
  input wire logic lockRequest,
  input wire logic lockHeldInternal,
  input wire logic lockTxSideDouble,
  input wire logic busLate,
  input wire logic busLateWrite,
  input wire logic slotStart,
  input wire logic idCheck,
  input wire logic [10:0] headerFrameId,
  input wire logic [10:0] ctrlFrameId,
  input wire logic txHeaderCheck,
  input wire logic txDynamic,
  input wire logic [6:0] txPayloadLength,
  input wire logic rxStaticCheck,
  input wire logic [6:0] rxPayloadLength,
  input wire logic rxPreamble,
  input wire logic rxNullFrame,
  input wire logic illegalAccess,
  output logic [15:0] errorFlags,
  output logic hostIfIrq,
  output logic [1:0] frameStore,
  output logic [1:0] fifoPush,
  output logic commandAccept,
  output logic bufCtrlWriteAccept,
  output logic lockGrant,
  output logic lateWriteDrop,
  output logic txSlotStop,
  output logic nmUpdate
);
  typedef struct packed {
    logic irqEnable;
    logic [6:0] maxDynLen;
    logic [6:0] staticLen;
    logic [3:0] nmLen;
    logic [6:0] lastUsed;
    logic irq;
    logic [1:0] frameStore;
    logic [1:0] fifoPush;
    logic commandAccept;
    logic bufCtrlWriteAccept;
    logic lockGrant;
    logic lateWriteDrop;
    logic txSlotStop;
    logic nmUpdate;
  } core_t;

  core_t coreReg;
  core_t coreNext;
  logic wrEn;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic [15:0] setEvents;
  logic [15:0] clearMask;
  logic [7:0] rxLenBytes;

  // ==========================================================================
  // Bus port
  ahb_reg_port u_port (
    .clk(clk),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  // ==========================================================================
  // Event detection
  // Payload length counts two-byte words, vector length counts bytes
  assign rxLenBytes = {rxPayloadLength, 1'b0};

  always_comb begin
    setEvents = 16'h0000;
    setEvents[error_flags_pkg::FRAME_LOST_CHAN_B_BIT] = frameDone[1] & bufferLocked[1]; // [R05]
    setEvents[error_flags_pkg::FRAME_LOST_CHAN_A_BIT] = frameDone[0] & bufferLocked[0]; // [R05]
    setEvents[error_flags_pkg::CTRL_COMMAND_IGNORED_BIT] = commandWrite & commandPending; // [R06]
    setEvents[error_flags_pkg::RX_FIFO_OVERRUN_CHAN_B_BIT] = fifoAppendReq[1] & fifoFull[1]; // [R07]
    setEvents[error_flags_pkg::RX_FIFO_OVERRUN_CHAN_A_BIT] = fifoAppendReq[0] & fifoFull[0]; // [R07]
    setEvents[error_flags_pkg::BUFFER_SEARCH_OVERRUN_BIT] = searchStart & searchRunning; // [R08]
    setEvents[error_flags_pkg::UNUSED_BUFFER_WRITE_BIT] =
      bufCtrlWrite & (bufCtrlIndex > coreReg.lastUsed); // [R09]
    setEvents[error_flags_pkg::BUFFER_LOCK_REFUSED_BIT] = lockRequest & lockHeldInternal; // [R10]
    setEvents[error_flags_pkg::DOUBLE_TX_LOCK_REFUSED_BIT] = lockRequest & lockTxSideDouble; // [R12]
    setEvents[error_flags_pkg::SYSTEM_BUS_LATE_BIT] = busLate; // [R13]
    setEvents[error_flags_pkg::FRAME_IDENT_MISMATCH_BIT] =
      idCheck & (headerFrameId != ctrlFrameId); // [R15]
    setEvents[error_flags_pkg::DYNAMIC_LENGTH_ERROR_BIT] =
      txHeaderCheck & txDynamic & (txPayloadLength > coreReg.maxDynLen); // [R16]
    setEvents[error_flags_pkg::STATIC_LENGTH_ERROR_BIT] =
      txHeaderCheck & ~txDynamic & (txPayloadLength != coreReg.staticLen); // [R17]
    setEvents[error_flags_pkg::NETMGMT_LENGTH_ERROR_BIT] =
      rxStaticCheck & (rxLenBytes < {4'h0, coreReg.nmLen}); // [R18]
    setEvents[error_flags_pkg::NETMGMT_NULL_FRAME_ERROR_BIT] =
      rxStaticCheck & rxPreamble & rxNullFrame; // [R19]
    setEvents[error_flags_pkg::ILLEGAL_MEMORY_ACCESS_BIT] = illegalAccess; // [R20]
  end

  assign clearMask = (wrEn && wrAddr == error_flags_pkg::FLAGS_OFFSET) ? wrData[15:0] : 16'h0000; // [R01]

  error_flag_bank u_bank (
    .clk(clk),
    .rst_b(rst_b),
    .setEvents(setEvents),
    .clearMask(clearMask),
    .flags(errorFlags)
  );

  // ==========================================================================
  // Read mux, unmapped words read as zero
  always_comb begin
    rdData = 32'h0000_0000;
    case (rdAddr)
      error_flags_pkg::FLAGS_OFFSET: begin
        rdData[15:0] = errorFlags;
      end
      error_flags_pkg::CONTROL_OFFSET: begin
        rdData[error_flags_pkg::IRQ_ENABLE_BIT] = coreReg.irqEnable;
      end
      error_flags_pkg::LIMITS_OFFSET: begin
        rdData[error_flags_pkg::MAX_DYN_LSB +: 7] = coreReg.maxDynLen;
        rdData[error_flags_pkg::STATIC_LEN_LSB +: 7] = coreReg.staticLen;
        rdData[error_flags_pkg::NM_LEN_LSB +: 4] = coreReg.nmLen;
        rdData[error_flags_pkg::LAST_USED_LSB +: 7] = coreReg.lastUsed;
      end
      error_flags_pkg::STATUS_OFFSET: begin
        rdData[error_flags_pkg::STATUS_IRQ_BIT] = coreReg.irq;
        rdData[error_flags_pkg::STATUS_SLOT_STOP_BIT] = coreReg.txSlotStop;
      end
      default: begin
        rdData = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================================
  // Configuration and grant logic
  always_comb begin
    coreNext = coreReg;
    if (wrEn && wrAddr == error_flags_pkg::CONTROL_OFFSET) begin
      coreNext.irqEnable = wrData[error_flags_pkg::IRQ_ENABLE_BIT];
    end
    if (wrEn && wrAddr == error_flags_pkg::LIMITS_OFFSET) begin
      coreNext.maxDynLen = wrData[error_flags_pkg::MAX_DYN_LSB +: 7];
      coreNext.staticLen = wrData[error_flags_pkg::STATIC_LEN_LSB +: 7];
      coreNext.nmLen = wrData[error_flags_pkg::NM_LEN_LSB +: 4];
      coreNext.lastUsed = wrData[error_flags_pkg::LAST_USED_LSB +: 7];
    end
    // Irq trails the flags by one cycle so it stays a clean flop output
    coreNext.irq = coreReg.irqEnable & (|errorFlags); // [R04]
    coreNext.frameStore = frameDone & ~bufferLocked; // [R05]
    coreNext.fifoPush = fifoAppendReq & ~fifoFull; // [R07]
    coreNext.commandAccept = commandWrite & ~commandPending; // [R06]
    coreNext.bufCtrlWriteAccept = bufCtrlWrite & (bufCtrlIndex <= coreReg.lastUsed); // [R09]
    // A refused lock is not queued; software has to ask again
    coreNext.lockGrant = lockRequest & ~lockHeldInternal & ~lockTxSideDouble; // [R10] [R11] [R12]
    coreNext.lateWriteDrop = busLate & busLateWrite; // [R14]
    // A late read in the new slot's first cycle wins over the resume
    if (busLate && !busLateWrite) begin
      coreNext.txSlotStop = 1'b1; // [R14]
    end else if (slotStart) begin
      coreNext.txSlotStop = 1'b0; // [R14]
    end
    // Short vectors still update; null frames never do
    coreNext.nmUpdate = rxStaticCheck & rxPreamble & ~rxNullFrame; // [R18] [R19]
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      coreReg <= '{irqEnable: error_flags_pkg::IRQ_ENABLE_RESET,
                   maxDynLen: error_flags_pkg::MAX_DYN_RESET,
                   staticLen: error_flags_pkg::STATIC_LEN_RESET,
                   nmLen: error_flags_pkg::NM_LEN_RESET,
                   lastUsed: error_flags_pkg::LAST_USED_RESET,
                   default: '0};
    end else begin
      coreReg <= coreNext;
    end
  end

  assign hostIfIrq = coreReg.irq;
  assign frameStore = coreReg.frameStore;
  assign fifoPush = coreReg.fifoPush;
  assign commandAccept = coreReg.commandAccept;
  assign bufCtrlWriteAccept = coreReg.bufCtrlWriteAccept;
  assign lockGrant = coreReg.lockGrant;
  assign lateWriteDrop = coreReg.lateWriteDrop;
  assign txSlotStop = coreReg.txSlotStop;
  assign nmUpdate = coreReg.nmUpdate;

  // ==========================================================================
  // Checks
  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b) // [R04]
    (coreReg.irqEnable && errorFlags != 16'h0000) |=> hostIfIrq)
    else $error("enabled flag did not raise irq");
  a_irq_masked: assert property (@(posedge clk) disable iff (!rst_b) // [R04]
    !coreReg.irqEnable |=> !hostIfIrq)
    else $error("irq raised while disabled");
  a_frame_lost: assert property (@(posedge clk) disable iff (!rst_b) // [R05]
    (frameDone[1] && bufferLocked[1]) |=> errorFlags[15] && !frameStore[1])
    else $error("locked buffer frame not flagged or stored");
  a_cmd_ignored: assert property (@(posedge clk) disable iff (!rst_b) // [R06]
    (commandWrite && commandPending) |=> errorFlags[13] && !commandAccept)
    else $error("command during pending not ignored");
  a_fifo_overrun: assert property (@(posedge clk) disable iff (!rst_b) // [R07]
    (fifoAppendReq[0] && fifoFull[0]) |=> errorFlags[11] && !fifoPush[0])
    else $error("fifo overrun on channel a missed");
  a_search_overrun: assert property (@(posedge clk) disable iff (!rst_b) // [R08]
    (searchStart && searchRunning) |=> errorFlags[10])
    else $error("search overrun not flagged");
  a_unused_write: assert property (@(posedge clk) disable iff (!rst_b) // [R09]
    (bufCtrlWrite && bufCtrlIndex > coreReg.lastUsed) |=> errorFlags[9] && !bufCtrlWriteAccept)
    else $error("write beyond last used buffer accepted");
  a_lock_refused: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
    (lockRequest && lockHeldInternal) |=> errorFlags[8] && !lockGrant)
    else $error("lock on held buffer granted");
  a_double_lock: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
    (lockRequest && lockTxSideDouble) |=> errorFlags[7] && !lockGrant)
    else $error("double buffer transmit lock granted");
  a_bus_late: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
    busLate |=> errorFlags[6] && (lateWriteDrop == $past(busLateWrite)))
    else $error("late bus access mishandled");
  a_slot_stop: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
    ((busLate && !busLateWrite) || (txSlotStop && !slotStart)) |=> txSlotStop)
    else $error("transmit stop not held until slot start");
  a_slot_resume: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
    (slotStart && !busLate) |=> !txSlotStop)
    else $error("transmit not resumed at slot start");
  a_ident_check: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
    (idCheck && headerFrameId != ctrlFrameId) |=> errorFlags[5])
    else $error("frame identifier mismatch missed");
  a_dyn_length: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
    (txHeaderCheck && txDynamic && txPayloadLength > coreReg.maxDynLen) |=> errorFlags[4])
    else $error("dynamic length error missed");
  a_static_length: assert property (@(posedge clk) disable iff (!rst_b) // [R17]
    (txHeaderCheck && !txDynamic && txPayloadLength != coreReg.staticLen) |=> errorFlags[3])
    else $error("static length error missed");
  a_nm_length: assert property (@(posedge clk) disable iff (!rst_b) // [R18]
    (rxStaticCheck && rxPreamble && !rxNullFrame && rxLenBytes < {4'h0, coreReg.nmLen})
      |=> errorFlags[2] && nmUpdate)
    else $error("short vector not flagged or not used");
  a_nm_null: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
    (rxStaticCheck && rxPreamble && rxNullFrame) |=> errorFlags[1] && !nmUpdate)
    else $error("null frame updated vector");
  a_illegal_access: assert property (@(posedge clk) disable iff (!rst_b) // [R20]
    illegalAccess |=> errorFlags[0])
    else $error("illegal access not flagged");
endmodule
`default_nettype wire

// ===== dv/host_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Host software, single word transfers
module host_sw_model (
  input wire logic clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  output logic timedOut
);
  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata, timedOut} = '0;
  end
  // Ready is looked at mid-cycle, where it has settled, to avoid an edge race
  task automatic waitRdy();
    int i;
    logic rdy;
    i = 0;
    do begin
      @(negedge clk);
      rdy = hreadyout;
      @(posedge clk);
      i++;
    end while (rdy !== 1'b1 && i < 20);
    if (rdy !== 1'b1) timedOut = 1'b1;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    // Read data phase shows a changing pattern, not stale data
    hwdata <= w ? d : ~hwdata;
    waitRdy();
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Random events against a reference of the flags, pulses, irq, transmit stop and register reads
module tb;
  logic clk = 0, rst_b = 0, evOn = 0, hready;
  logic [1:0] frameDone = 0, bufferLocked = 0, fifoAppendReq = 0, fifoFull = 0, frameStore, fifoPush, htrans;
  logic commandWrite = 0, commandPending = 0, searchStart = 0, searchRunning = 0, bufCtrlWrite = 0;
  logic lockRequest = 0, lockHeldInternal = 0, lockTxSideDouble = 0, busLate = 0, busLateWrite = 0;
  logic slotStart = 0, idCheck = 0, txHeaderCheck = 0, txDynamic = 0, rxStaticCheck = 0;
  logic rxPreamble = 0, rxNullFrame = 0, illegalAccess = 0;
  logic [6:0] bufCtrlIndex = 0, txPayloadLength = 0, rxPayloadLength = 0;
  logic [10:0] headerFrameId = 0, ctrlFrameId = 0;
  logic hsel, hwrite, hreadyout, hresp, timedOut, hostIfIrq, commandAccept, bufCtrlWriteAccept;
  logic lockGrant, lateWriteDrop, txSlotStop, nmUpdate, expEn, expIrq, expStop, wPend;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, expLim, rv, r, q, p;
  logic [15:0] expFlags, errorFlags, setV;
  logic [8:0] expPulse;
  logic [7:0] wA;
  int seed = 32'h1244, err_total = 0, n_checks = 0, k;
  assign hready = hreadyout;
  host_interface_error_flags uut (.*);
  host_sw_model host (.*);
  initial forever #10 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [15:0] setVec();
    setVec = {frameDone & bufferLocked, commandWrite & commandPending, fifoAppendReq & fifoFull,
      searchStart & searchRunning, bufCtrlWrite && (bufCtrlIndex > expLim[30:24]),
      lockRequest & lockHeldInternal, lockRequest & lockTxSideDouble, busLate,
      idCheck && (headerFrameId != ctrlFrameId), txHeaderCheck & txDynamic && (txPayloadLength > expLim[6:0]),
      txHeaderCheck & ~txDynamic && (txPayloadLength != expLim[14:8]),
      rxStaticCheck && ({rxPayloadLength, 1'b0} < {4'h0, expLim[19:16]}),
      rxStaticCheck & rxPreamble & rxNullFrame, illegalAccess};
  endfunction
  function automatic logic [31:0] regVal(input logic [7:0] a);
    case (a)
      8'h00: regVal = {16'h0, expFlags};
      8'h04: regVal = {31'h0, expEn};
      8'h08: regVal = expLim;
      8'h0c: regVal = {30'h0, expStop, expIrq};
      default: regVal = 32'h0;
    endcase
  endfunction
  // ====================
  // Reference model and event drive
  always @(posedge clk) begin
    if (!rst_b) begin
      {expFlags, expPulse, expEn, expIrq, expStop, wPend} = '0;
      expLim = 32'h7f00_007f;
    end else begin
      chk("errorFlags", expFlags, errorFlags);
      chk("pulses", expPulse, {frameStore, fifoPush, commandAccept, bufCtrlWriteAccept, lockGrant, lateWriteDrop, nmUpdate});
      chk("irq stop", {expIrq, expStop}, {hostIfIrq, txSlotStop});
      chk("hresp", 32'h0, hresp);
      expIrq = expEn & |expFlags;
      expStop = busLate & ~busLateWrite | expStop & ~slotStart;
      setV = setVec();
      expPulse = {frameDone & ~bufferLocked, fifoAppendReq & ~fifoFull, commandWrite & ~commandPending,
        bufCtrlWrite && (bufCtrlIndex <= expLim[30:24]), lockRequest & ~lockHeldInternal & ~lockTxSideDouble,
        busLate & busLateWrite, rxStaticCheck & rxPreamble & ~rxNullFrame};
      if (wPend && wA == 8'h00) expFlags = expFlags & ~hwdata[15:0];
      if (wPend && wA == 8'h04) expEn = hwdata[0];
      if (wPend && wA == 8'h08) expLim = hwdata & 32'h7f0f_7f7f;
      // Set wins over a clear landing on the same edge
      expFlags = expFlags | setV;
      wPend = hsel & htrans[1] & hreadyout & hwrite & (hsize == 3'h2);
      wA = haddr[7:0];
    end
    r = $random(seed);
    q = $random(seed);
    p = evOn ? r & q : 32'h0;
    {frameDone, fifoAppendReq, commandWrite, searchStart, bufCtrlWrite, lockRequest, busLate, slotStart,
      idCheck, txHeaderCheck, rxStaticCheck, illegalAccess} <= p[13:0];
    {bufferLocked, fifoFull, commandPending, searchRunning, lockHeldInternal, lockTxSideDouble,
      busLateWrite, txDynamic, rxPreamble, rxNullFrame} <= q[11:0];
    // Small lengths so that every limit boundary is hit often
    bufCtrlIndex <= {4'h0, r[18:16]};
    txPayloadLength <= {4'h0, q[18:16]};
    rxPayloadLength <= {4'h0, r[22:20]};
    headerFrameId <= r[30:20];
    ctrlFrameId <= r[30:20] ^ {10'h0, q[31]};
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 40; k++) begin
      for (int a = 0; a < 36; a += 4) begin
        host.xfer(1'b0, a, 32'h0, rv);
        chk("read data", regVal(a[7:0]), rv);
      end
      evOn <= 1'b1;
      repeat (4) host.xfer(1'b1, 32'h0, $random(seed), rv);
      host.xfer(1'b1, 32'h4, $random(seed), rv);
      evOn <= 1'b0;
      repeat (3) @(posedge clk);
      host.xfer(1'b1, 32'h8, $random(seed) & 32'h8787_8787, rv);
      host.xfer(1'b1, 32'h20, 32'hffff_ffff, rv);
      repeat (2) @(posedge clk);
    end
    if (timedOut) err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
